/* rtl/pulse_pkg.sv */
// Package with constants for the single pulse output channel
package pulse_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_DURATION = 8'h04;
  localparam logic [7:0] OFF_DELAY    = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_CONFIG   = 8'h10;
  // Control register bit positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_OWNER   = 1;
  localparam int CTRL_DIR_A   = 2;
  localparam int CTRL_DIR_B   = 3;
  // Config register fields
  localparam int CFG_ROLE     = 0;
  localparam int CFG_HSPEED   = 1;
  localparam int CFG_STOP_A   = 2;
  localparam int CFG_STOP_B   = 3;
  localparam int CFG_FILT_LSB = 4;
  localparam int CFG_FILT_W   = 4;
  // Status register bit positions
  localparam int STS_PENDING  = 0;
  localparam int STS_ACTIVE   = 1;
  localparam int STS_ERROR    = 2;
  localparam int STS_OUT_A    = 3;
  localparam int STS_CNT_LSB  = 4;
  // Widths
  localparam int SEQ_CNT_W    = 4;
  localparam int FILT_CNT_W   = 15;
  // Reset values
  localparam logic [3:0]  FILT_CODE_RST = 4'h2;
  localparam logic [31:0] DURATION_RST  = 32'h0000000A;
  // Timing
  localparam int CLK_MHZ         = 100;
  localparam int TICK_NS         = 1000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int MIN_DUR_HS_US   = 2;
  localparam int MIN_DUR_LS_US   = 10;
  localparam int MAX_DUR_US      = 85000000;
  // Filter times in microseconds, indexed by code
  localparam int FILT_US_0 = 4;
  localparam int FILT_US_1 = 50;
  localparam int FILT_US_2 = 100;
  localparam int FILT_US_3 = 400;
  localparam int FILT_US_4 = 800;
  localparam int FILT_US_5 = 1600;
  localparam int FILT_US_6 = 3200;
  localparam int FILT_US_7 = 12800;
  localparam int FILT_US_8 = 20000;
  // Channel sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_PULSE} seq_state_e;
endpackage

/* rtl/us_tick.sv */
// Microsecond tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module us_tick
  import pulse_pkg::*;
(
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic CE,
  output logic      TICK
);
  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt_q;  // Cycle counter within one microsecond

  // Count cycles and pulse once per microsecond
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= '0;
      TICK  <= 1'b0;
    end else if (CE) begin
      TICK  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule // us_tick
`default_nettype wire

/* rtl/trig_filter.sv */
// Input noise filter: accepts a new level, high or low, that stays stable for the set time
`timescale 1ns/1ps
`default_nettype none
module trig_filter
  import pulse_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  TICK,
  input  wire logic                  RAW_IN,
  input  wire logic [CFG_FILT_W-1:0] CODE,
  output logic                       FILTERED
);
  logic [FILT_CNT_W-1:0] stable_q;  // Microseconds the raw level differs from output

  // Filter time for a code; unknown codes use the longest time
  function automatic logic [FILT_CNT_W-1:0] filt_us(input logic [CFG_FILT_W-1:0] c);
    unique case (c)
      4'h0:    filt_us = FILT_CNT_W'(FILT_US_0);
      4'h1:    filt_us = FILT_CNT_W'(FILT_US_1);
      4'h2:    filt_us = FILT_CNT_W'(FILT_US_2);
      4'h3:    filt_us = FILT_CNT_W'(FILT_US_3);
      4'h4:    filt_us = FILT_CNT_W'(FILT_US_4);
      4'h5:    filt_us = FILT_CNT_W'(FILT_US_5);
      4'h6:    filt_us = FILT_CNT_W'(FILT_US_6);
      4'h7:    filt_us = FILT_CNT_W'(FILT_US_7);
      default: filt_us = FILT_CNT_W'(FILT_US_8);
    endcase
  endfunction

  // Output changes only after the raw level held for the full time
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stable_q <= '0;
      FILTERED <= 1'b0;
    end else if (CE) begin
      if (RAW_IN == FILTERED) begin
        stable_q <= '0;
      end else if (TICK) begin
        if (stable_q + 1'b1 >= filt_us(CODE)) begin
          FILTERED <= RAW_IN;
          stable_q <= '0;
        end else begin
          stable_q <= stable_q + 1'b1;
        end
      end
    end
  end
endmodule // trig_filter
`default_nettype wire

/* rtl/single_pulse_channel.sv */
// Single pulse output channel with APB register access
// How it works
// R1: After start delay, out_a high for duration
// R2: Plain input role: delay starts on request rise
// R3: Program starts by raising the start request
// R4: Pending bit shows held start request
// R5: Trigger role: first trigger rise starts sequence
// R6: Trigger edges during a sequence are ignored
// R7: Trigger accepted after filter time; active set
// R8: Sequence ends with pulse; active cleared
// R9: out_a low, high, low across the phases
// R10: Request fall aborts at once, clears outputs
// R11: Program must request again after a cancel
// R12: Duration is 32-bit microseconds, range by speed
// R13: Changed duration ends pulse at new value
// R14: Duration below elapsed: stop, set error
// R15: Error cleared when next sequence begins
// R16: Owner select picks pulse logic or direct bits
// R17: Host stop drives outputs to configured state
// R18: Completed sequences counted and reported
// R19: Four-bit count: set 1, or increment
// R20: Filter time chosen by code, default 0.1 ms
// R21: Delay and duration timed in microsecond ticks
`timescale 1ns/1ps
`default_nettype none
module single_pulse_channel
  import pulse_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TRIGGER_IN,
  input  wire logic        HOST_STOP,
  output logic             OUT_A,
  output logic             OUT_B
);
  // Control register fields
  logic        sw_start_request_q;   // Software start request
  logic        output_owner_select_q; // 1: pulse logic drives out_a
  logic        direct_out_a_q;       // Direct level for out_a
  logic        direct_out_b_q;       // Direct level for out_b
  // Configuration register fields
  logic        input_role_select_q;  // 1: external trigger role
  logic        high_speed_q;         // High-speed output enabled
  logic        stop_out_a_q;         // out_a level during host stop
  logic        stop_out_b_q;         // out_b level during host stop
  logic [CFG_FILT_W-1:0] filt_code_q; // Trigger filter time code
  // Timing values
  logic [31:0] duration_q;           // Pulse duration in microseconds
  logic [31:0] delay_q;              // Start delay in microseconds
  // Sequence state
  seq_state_e  state_q;              // Sequence phase
  logic [31:0] elapsed_q;            // Microseconds elapsed in phase
  logic        error_q;              // Duration error flag
  logic [SEQ_CNT_W-1:0] seq_cnt_q;   // Completed sequence counter
  logic        start_prev_q;         // Previous request level
  logic        trig_prev_q;          // Previous filtered trigger level
  logic        pulse_out_q;          // Pulse logic output level
  // Helpers
  logic        tick;                 // One microsecond tick
  logic        trig_filt;            // Filtered trigger level
  logic        wr_en;                // APB write in access phase
  logic        req_rise;             // Request rose this cycle
  logic        req_fall;             // Request fell this cycle
  logic        trig_rise;            // Filtered trigger rose this cycle
  logic        begin_seq;            // A sequence begins this cycle
  logic        end_ok;               // Pulse completes normally
  logic        shrink_err;           // Duration below elapsed time
  logic [31:0] min_dur;              // Least legal duration
  logic [31:0] dur_eff;              // Duration clamped to legal range

  // Microsecond timebase
  us_tick u_tick (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .CE      (CE),
    .TICK    (tick)              // R21
  );

  // Trigger input noise filter
  trig_filter u_filt (
    .REF_CLK  (REF_CLK),
    .RST      (RST),
    .CE       (CE),
    .TICK     (tick),
    .RAW_IN   (TRIGGER_IN),
    .CODE     (filt_code_q),     // R20
    .FILTERED (trig_filt)        // R7
  );

  // Clamp a duration into the legal range for the speed setting
  function automatic logic [31:0] clamp_dur(input logic [31:0] d, input logic [31:0] lo);
    if (d < lo) begin
      clamp_dur = lo;
    end else if (d > 32'(MAX_DUR_US)) begin
      clamp_dur = 32'(MAX_DUR_US);
    end else begin
      clamp_dur = d;
    end
  endfunction

  // APB: zero wait states, error on unmapped address
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(PADDR == OFF_CTRL || PADDR == OFF_DURATION ||
                   PADDR == OFF_DELAY || PADDR == OFF_STATUS || PADDR == OFF_CONFIG);

  // Read data mux, registered so data comes from a flip-flop
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        OFF_CTRL:     PRDATA <= {28'h0000000, direct_out_b_q, direct_out_a_q,
                                 output_owner_select_q, sw_start_request_q};
        OFF_DURATION: PRDATA <= duration_q;
        OFF_DELAY:    PRDATA <= delay_q;
        OFF_STATUS:   PRDATA <= {24'h000000, seq_cnt_q, pulse_out_q, error_q,
                                 (state_q inside {ST_DELAY, ST_PULSE}), // R7 R8
                                 sw_start_request_q}; // R4 R18
        OFF_CONFIG:   PRDATA <= {24'h000000, filt_code_q, stop_out_b_q, stop_out_a_q,
                                 high_speed_q, input_role_select_q};
        default:      PRDATA <= '0;
      endcase
    end
  end

  // Control register writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sw_start_request_q    <= 1'b0;
      output_owner_select_q <= 1'b0;
      direct_out_a_q        <= 1'b0;
      direct_out_b_q        <= 1'b0;
    end else if (CE && wr_en && PADDR == OFF_CTRL) begin
      sw_start_request_q    <= PWDATA[CTRL_START]; // R3
      output_owner_select_q <= PWDATA[CTRL_OWNER];
      direct_out_a_q        <= PWDATA[CTRL_DIR_A];
      direct_out_b_q        <= PWDATA[CTRL_DIR_B];
    end
  end

  // Configuration register writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      input_role_select_q <= 1'b0;
      high_speed_q        <= 1'b0;
      stop_out_a_q        <= 1'b0;
      stop_out_b_q        <= 1'b0;
      filt_code_q         <= FILT_CODE_RST; // R20
    end else if (CE && wr_en && PADDR == OFF_CONFIG) begin
      input_role_select_q <= PWDATA[CFG_ROLE];
      high_speed_q        <= PWDATA[CFG_HSPEED];
      stop_out_a_q        <= PWDATA[CFG_STOP_A];
      stop_out_b_q        <= PWDATA[CFG_STOP_B];
      filt_code_q         <= PWDATA[CFG_FILT_LSB +: CFG_FILT_W];
    end
  end

  // Duration and delay writes; duration is clamped to its legal range
  assign min_dur = high_speed_q ? 32'(MIN_DUR_HS_US) : 32'(MIN_DUR_LS_US);
  assign dur_eff = clamp_dur(duration_q, min_dur); // R12
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      duration_q <= DURATION_RST;
      delay_q    <= '0;
    end else if (CE && wr_en) begin
      if (PADDR == OFF_DURATION) begin
        duration_q <= PWDATA; // R12
      end
      if (PADDR == OFF_DELAY) begin
        delay_q <= PWDATA;
      end
    end
  end

  // Edge detection on request and filtered trigger
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      start_prev_q <= 1'b0;
      trig_prev_q  <= 1'b0;
    end else if (CE) begin
      start_prev_q <= sw_start_request_q;
      trig_prev_q  <= trig_filt;
    end
  end
  assign req_rise  = sw_start_request_q && !start_prev_q;
  assign req_fall  = !sw_start_request_q && start_prev_q;
  assign trig_rise = trig_filt && !trig_prev_q;

  // Sequence begins on request rise or first accepted trigger rise
  always_comb begin
    begin_seq = 1'b0;
    if (!input_role_select_q) begin
      begin_seq = req_rise && state_q == ST_IDLE; // R2
    end else begin
      begin_seq = state_q == ST_ARMED && trig_rise && sw_start_request_q; // R5 R6 R7
    end
  end
  assign end_ok     = state_q == ST_PULSE && tick && (elapsed_q + 32'h1 >= dur_eff); // R13
  assign shrink_err = state_q == ST_PULSE && (dur_eff < elapsed_q); // R14

  // Sequence state machine
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q     <= ST_IDLE;
      elapsed_q   <= '0;
      pulse_out_q <= 1'b0;
    end else if (CE) begin
      if (!sw_start_request_q) begin
        state_q     <= ST_IDLE; // R10
        elapsed_q   <= '0;
        pulse_out_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            // Trigger role waits armed; plain role starts directly
            if (input_role_select_q && req_rise) begin
              state_q <= ST_ARMED;
            end else if (begin_seq) begin
              elapsed_q   <= '0;
              state_q     <= (delay_q == '0) ? ST_PULSE : ST_DELAY;
              pulse_out_q <= (delay_q == '0);
            end
          end
          ST_ARMED: begin
            if (begin_seq) begin
              elapsed_q   <= '0;
              state_q     <= (delay_q == '0) ? ST_PULSE : ST_DELAY;
              pulse_out_q <= (delay_q == '0);
            end
          end
          ST_DELAY: begin
            if (tick) begin
              if (elapsed_q + 32'h1 >= delay_q) begin
                state_q     <= ST_PULSE; // R1
                elapsed_q   <= '0;
                pulse_out_q <= 1'b1; // R9
              end else begin
                elapsed_q <= elapsed_q + 32'h1; // R21
              end
            end
          end
          ST_PULSE: begin
            if (shrink_err || end_ok) begin
              // Trigger role re-arms for the next trigger edge
              state_q     <= input_role_select_q ? ST_ARMED : ST_IDLE; // R8 R14
              elapsed_q   <= '0;
              pulse_out_q <= 1'b0; // R9
            end else if (tick) begin
              elapsed_q <= elapsed_q + 32'h1;
            end
          end
        endcase
      end
    end
  end

  // Duration error: set on shrink, cleared at next sequence start
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      error_q <= 1'b0;
    end else if (CE) begin
      if (shrink_err && sw_start_request_q) begin
        error_q <= 1'b1; // R14
      end else if (begin_seq && sw_start_request_q) begin
        error_q <= 1'b0; // R15
      end
    end
  end

  // Completed sequence counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      seq_cnt_q <= '0;
    end else if (CE && end_ok && !shrink_err && sw_start_request_q) begin
      if (input_role_select_q) begin
        seq_cnt_q <= seq_cnt_q + 1'b1; // R18 R19
      end else begin
        seq_cnt_q <= SEQ_CNT_W'(1); // R19
      end
    end
  end

  // Output selection: host stop, direct control or pulse logic
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      OUT_A <= 1'b0;
      OUT_B <= 1'b0;
    end else if (CE) begin
      if (HOST_STOP) begin
        OUT_A <= stop_out_a_q; // R17
        OUT_B <= stop_out_b_q;
      end else if (output_owner_select_q) begin
        OUT_A <= pulse_out_q && sw_start_request_q; // R16 R10
        OUT_B <= 1'b0;
      end else begin
        OUT_A <= direct_out_a_q; // R16
        OUT_B <= direct_out_b_q;
      end
    end
  end
endmodule // single_pulse_channel
`default_nettype wire

/* test/single_pulse_channel_assertions.sv */
// Checker that watches the ports of the single pulse channel
`timescale 1ns/1ps
`default_nettype none
module single_pulse_channel_assertions
  import pulse_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        HOST_STOP,
  input wire logic        OUT_A,
  input wire logic        OUT_B
);
  logic       wr_acc;   // Write taken at this edge
  logic       mapped;   // Address hits a register
  logic [3:0] ctrl_q;   // Shadow of start, owner, direct A, direct B
  logic [1:0] stop_q;   // Shadow of stop levels A and B
  assign wr_acc = PSEL && PENABLE && PWRITE && PREADY && CE;
  assign mapped = PADDR inside {OFF_CTRL, OFF_DURATION, OFF_DELAY, OFF_STATUS, OFF_CONFIG};
  // Follows control writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= 4'h0;
    end else if (wr_acc && PADDR == OFF_CTRL) begin
      ctrl_q <= PWDATA[3:0];
    end
  end
  // Follows configuration writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stop_q <= 2'h0;
    end else if (wr_acc && PADDR == OFF_CONFIG) begin
      stop_q <= PWDATA[CFG_STOP_B:CFG_STOP_A];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Program owns the outputs and keeps its bits steady
  sequence direct_held;
    (!ctrl_q[CTRL_OWNER] && !HOST_STOP && CE && $stable(ctrl_q)) [*3];
  endsequence
  // Host stop held with steady stop levels
  sequence stop_held;
    (HOST_STOP && CE && $stable(stop_q)) [*3];
  endsequence
  // Start request dropped while pulse logic owns the output
  sequence abort_write;
    wr_acc && PADDR == OFF_CTRL && !PWDATA[CTRL_START] && PWDATA[CTRL_OWNER]
      && ctrl_q[CTRL_START] && !HOST_STOP;
  endsequence
  // Pulse begins under pulse logic control
  sequence pulse_rise;
    $rose(OUT_A) && ctrl_q[CTRL_OWNER] && ctrl_q[CTRL_START] && !HOST_STOP;
  endsequence
  a_direct_a_level: assert property (direct_held |-> OUT_A == ctrl_q[CTRL_DIR_A])
    else $error("out_a differs from direct bit");
  a_direct_b_level: assert property (direct_held |-> OUT_B == ctrl_q[CTRL_DIR_B])
    else $error("out_b differs from direct bit");
  a_stop_a_level: assert property (stop_held |-> OUT_A == stop_q[0])
    else $error("out_a differs from stop level");
  a_stop_b_level: assert property (stop_held |-> OUT_B == stop_q[1])
    else $error("out_b differs from stop level");
  a_idle_out_low: assert property (
    (ctrl_q[CTRL_OWNER] && !ctrl_q[CTRL_START] && !HOST_STOP) [*3] |-> !OUT_A)
    else $error("out_a high without start request");
  a_abort_out_low: assert property (abort_write |-> ##[1:3] !OUT_A)
    else $error("out_a not cleared on abort");
  a_pulse_min_width: assert property (pulse_rise |->
    (OUT_A || !ctrl_q[CTRL_START] || HOST_STOP || wr_acc) [*8])
    else $error("pulse shorter than minimum");
  a_ready_always: assert property (PREADY)
    else $error("pready low");
  a_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("pslverr wrong for address");
endmodule // single_pulse_channel_assertions
bind single_pulse_channel single_pulse_channel_assertions u_single_pulse_channel_assertions (
  .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .HOST_STOP(HOST_STOP), .OUT_A(OUT_A), .OUT_B(OUT_B));
`default_nettype wire

/* test/control_program.sv */
// Model of the control program: APB master and trigger source
`timescale 1ns/1ps
`default_nettype none
module control_program
  import pulse_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             trig
);
  logic hung;  // An access never saw pready
  // Idle bus and low trigger at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0;
    trig = 1'b0;
    hung = 1'b0;
  end
  // One APB transfer; released lines show inverted values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!pready && n < 50);
    hung = hung | !pready;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Control write; a fresh start is a 0 to 1 change of bit 0
  task automatic set_ctrl(input logic [3:0] bits);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, OFF_CTRL, {28'h0, bits}, r, e);
  endtask
  // Trigger level change right after an edge
  task automatic set_trig(input logic v);
    @(posedge ref_clk);
    trig <= v;
  endtask
endmodule // control_program
`default_nettype wire

/* test/tb_single_pulse_channel.sv */
// Self-checking testbench for the single pulse channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_single_pulse_channel
  import pulse_pkg::*;
;
  logic        ref_clk;    // System clock
  logic        rst;        // Reset
  logic        host_stop;  // Host stop condition
  logic        ce;         // Clock enable
  logic        psel;       // APB select
  logic        penable;    // APB enable
  logic        pwrite;     // APB direction
  logic [7:0]  paddr;      // APB address
  logic [31:0] pwdata;     // APB write data
  logic [31:0] prdata;     // APB read data
  logic        pready;     // APB ready
  logic        pslverr;    // APB error
  logic        trig;       // Trigger line
  logic        out_a;      // Output A
  logic        out_b;      // Output B
  logic [31:0] rdata;      // Last read data
  logic        err;        // Last read error
  int          errors;     // Mismatch count
  int          compares;   // Comparison count
  int          seed;       // Random seed
  int          n, w, dur, del, i;
  single_pulse_channel u_single_pulse_channel (.REF_CLK(ref_clk), .RST(rst), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRIGGER_IN(trig),
    .HOST_STOP(host_stop), .OUT_A(out_a), .OUT_B(out_b));
  control_program u_prog (.ref_clk(ref_clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .trig(trig));
  // Clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // Expected status word: count and flags {out, error, active, pending}
  function automatic logic [31:0] sts(input logic [3:0] c, input logic [3:0] f);
    return {24'h0, c, f};
  endfunction
  // Measured cycles match a time in microseconds within two ticks
  function automatic logic near(input int cyc, input int us);
    return cyc >= (us - 2) * TICK_CYCLES && cyc <= (us + 2) * TICK_CYCLES;
  endfunction
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_prog.xfer(1'b1, a, d, r, e);
  endtask
  // Register read
  task automatic rd(input logic [7:0] a);
    u_prog.xfer(1'b0, a, 32'h0, rdata, err);
  endtask
  // Bounded wait for a level on output A
  task automatic wait_out(input logic v, output int cyc);
    cyc = 0;
    while (out_a !== v && cyc < 20000) begin
      @(posedge ref_clk);
      cyc++;
    end
    if (out_a !== v) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    if (u_prog.hung) errors++;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    errors = 0;
    compares = 0;
    seed = 32'h3c4f;
    rst = 1'b1;
    host_stop = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFF_CONFIG);
    `CHK(rdata, {24'h0, FILT_CODE_RST, 4'h0})
    rd(OFF_DURATION);
    `CHK(rdata, DURATION_RST)
    rd(OFF_STATUS);
    `CHK(rdata, sts(4'h0, 4'h0))
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14);
    `CHK({err, rdata}, 33'h100000000)
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      u_prog.set_ctrl({i[1:0], 2'b00});
      repeat (3) @(posedge ref_clk);
      `CHK({out_b, out_a}, i[1:0])
    end
    ce <= 1'b0;
    u_prog.set_ctrl(4'h0);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({out_b, out_a}, 2'b11)
    $display("test direct done");
    for (i = 0; i < 2; i++) begin
      dur = 10 + ($random(seed) & 7);
      del = i * (1 + ($random(seed) & 3));
      wr(OFF_DURATION, 32'(dur));
      wr(OFF_DELAY, 32'(del));
      u_prog.set_ctrl(4'h3);
      wait_out(1'b1, n);
      `CHK(near(n, del), 1'b1)
      rd(OFF_STATUS);
      `CHK(rdata, sts(4'(i), 4'hB))
      wait_out(1'b0, w);
      `CHK(near(w + 3, dur), 1'b1)
      repeat (3) @(posedge ref_clk);
      rd(OFF_STATUS);
      `CHK(rdata, sts(4'h1, 4'h1))
      u_prog.set_ctrl(4'h2);
    end
    $display("test plain done");
    wr(OFF_DURATION, 32'd50);
    u_prog.set_ctrl(4'h3);
    wait_out(1'b1, n);
    repeat (500) @(posedge ref_clk);
    u_prog.set_ctrl(4'h2);
    repeat (3) @(posedge ref_clk);
    `CHK(out_a, 1'b0)
    rd(OFF_STATUS);
    `CHK(rdata, sts(4'h1, 4'h0))
    $display("test abort done");
    wr(OFF_DELAY, 32'd0);
    wr(OFF_DURATION, 32'd10);
    u_prog.set_ctrl(4'h3);
    wait_out(1'b1, n);
    repeat (300) @(posedge ref_clk);
    wr(OFF_DURATION, 32'd20);
    wait_out(1'b0, w);
    `CHK(near(w + 303, 20), 1'b1)
    u_prog.set_ctrl(4'h2);
    wr(OFF_DURATION, 32'd30);
    u_prog.set_ctrl(4'h3);
    wait_out(1'b1, n);
    repeat (1500) @(posedge ref_clk);
    wr(OFF_DURATION, 32'd10);
    repeat (3) @(posedge ref_clk);
    `CHK(out_a, 1'b0)
    rd(OFF_STATUS);
    `CHK(rdata, sts(4'h1, 4'h5))
    u_prog.set_ctrl(4'h2);
    u_prog.set_ctrl(4'h3);
    rd(OFF_STATUS);
    `CHK(rdata[STS_ERROR], 1'b0)
    wait_out(1'b0, w);
    $display("test duration change done");
    u_prog.set_ctrl(4'h2);
    wr(OFF_CONFIG, 32'h01);
    wr(OFF_DELAY, 32'd5);
    wr(OFF_DURATION, 32'd20);
    u_prog.set_ctrl(4'h3);
    repeat (1000) @(posedge ref_clk);
    u_prog.set_trig(1'b1);
    repeat (200) @(posedge ref_clk);
    u_prog.set_trig(1'b0);
    repeat (1500) @(posedge ref_clk);
    `CHK(out_a, 1'b0)
    rd(OFF_STATUS);
    `CHK(rdata, sts(4'h1, 4'h1))
    for (i = 2; i < 4; i++) begin
      u_prog.set_trig(1'b1);
      wait_out(1'b1, n);
      `CHK(near(n, 9), 1'b1)
      u_prog.set_trig(1'b0);
      repeat (600) @(posedge ref_clk);
      u_prog.set_trig(1'b1);
      wait_out(1'b0, w);
      `CHK(near(w + 602, 20), 1'b1)
      u_prog.set_trig(1'b0);
      repeat (600) @(posedge ref_clk);
      rd(OFF_STATUS);
      `CHK(rdata, sts(4'(i), 4'h1))
    end
    $display("test trigger done");
    u_prog.set_ctrl(4'h0);
    wr(OFF_CONFIG, 32'h02);
    wr(OFF_DURATION, 32'd1);
    u_prog.set_ctrl(4'h3);
    wait_out(1'b1, n);
    wait_out(1'b0, w);
    `CHK(near(w, 2), 1'b1)
    u_prog.set_ctrl(4'h0);
    wr(OFF_CONFIG, 32'h2C);
    host_stop <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({out_b, out_a}, 2'b11)
    wr(OFF_CONFIG, 32'h24);
    repeat (3) @(posedge ref_clk);
    `CHK({out_b, out_a}, 2'b01)
    host_stop <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK({out_b, out_a}, 2'b00)
    $display("test stop done");
    report_and_stop();
  end
endmodule // tb_single_pulse_channel
`default_nettype wire
